// ===== spkh_consts.vh
// constants for the serial key-scan host controller
`ifndef SPKH_CONSTS_VH
`define SPKH_CONSTS_VH
// register byte offsets on the ahb-lite slave
`define SPKH_OFF_CTRL     8'h00
`define SPKH_OFF_TXDATA   8'h04
`define SPKH_OFF_STATUS   8'h08
`define SPKH_OFF_RXDATA   8'h0C
`define SPKH_OFF_PINS     8'h10
`define SPKH_OFF_CLKDIV   8'h14
// ctrl register fields
`define SPKH_CTRL_START   0
`define SPKH_CTRL_BYTE    1
`define SPKH_CTRL_END     2
`define SPKH_CTRL_RS      3
`define SPKH_CTRL_RW      4
`define SPKH_CTRL_ID      5
// status register fields
`define SPKH_ST_BUSY      0
`define SPKH_ST_RXV       1
`define SPKH_ST_IRQ       2
`define SPKH_ST_SEL       3
// pins register fields
`define SPKH_PIN_ISB      0
`define SPKH_PIN_ISC      1
`define SPKH_PIN_MID      2
`define SPKH_PIN_RSP      3
// fixed upper five bits of the chip address; the value is arbitrary
`define SPKH_ADDR_HI      5'h13
// operation codes: register select, read/write
`define SPKH_OP_WR_INSTR  2'h0
`define SPKH_OP_RD_KEYS   2'h1
`define SPKH_OP_WR_RAM    2'h2
`define SPKH_OP_RD_RAM    2'h3
// reset values
`define SPKH_CLKDIV_RST   8'h08
`define SPKH_PINS_RST     4'h0
`endif

// ===== spkh_sync.v
// three-flop synchroniser with agreement filter for one pin input
`timescale 1ns/1ns
`default_nettype none
module spkh_sync
(
   input  wire clk,    // system clock
   input  wire reset,  // async reset, active high
   input  wire d_in,   // asynchronous pin
   output reg  q_out   // filtered level
);
   reg s1_r; // first stage, read only by s2_r
   reg s2_r; // second stage
   reg s3_r; // third stage

   // shift chain; a change counts once stages two and three agree
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         s1_r  <= 1'b1;
         s2_r  <= 1'b1;
         s3_r  <= 1'b1;
         q_out <= 1'b1;
      end
      else
      begin
         s1_r <= d_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r)
            q_out <= s3_r;
      end
   end
endmodule // spkh_sync
`default_nettype wire

// ===== spkh_host.v
// host controller driving the serial key-scan device over cs, sclk and sda
//
// Our own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none
`include "spkh_consts.vh"
module spkh_host
#(
   parameter DIV_W = 8 // width of the serial clock half-period divider
)
(
   input  wire        clk,        // 100 MHz system clock
   input  wire        reset,      // async reset, active high
   input  wire [31:0] haddr,      // ahb address
   input  wire [1:0]  htrans,     // ahb transfer type
   input  wire        hwrite,     // ahb write flag
   input  wire [2:0]  hsize,      // ahb size, word only
   input  wire [31:0] hwdata,     // ahb write data
   input  wire        hsel,       // ahb slave select
   input  wire        hready,     // ahb bus ready
   output reg  [31:0] hrdata,     // ahb read data
   output reg         hreadyout,  // ahb slave ready
   output reg         hresp,      // ahb response, always okay
   output reg         cs_n,       // device chip select, active low
   output reg         sclk,       // serial clock to the device
   output reg         sda_o,      // serial data out
   output reg         sda_oe,     // serial data drive enable, high drives
   input  wire        sda_i,      // serial data in
   input  wire        irq_n,      // device key interrupt, active low
   output reg         iface_sel_b,            // mode pin b
   output reg         iface_sel_c,            // mode pin c
   output reg         mode_or_address_low_pin,// id pin
   output reg         register_select         // standby strobe pattern pin
);
   localparam ST_IDLE  = 3'h0; // deselected
   localparam ST_SETUP = 3'h1; // chip select low, first bit set up
   localparam ST_LOW   = 3'h2; // sclk low half
   localparam ST_HIGH  = 3'h3; // sclk high half
   localparam ST_WAIT  = 3'h4; // byte done, selected, waiting for order
   localparam ST_END   = 3'h5; // end hold, chip select still low until it rises

   reg [2:0]       state_r;     // serial sequencer state
   reg [DIV_W-1:0] div_r;       // half-period counter
   reg [DIV_W-1:0] clkdiv_r;    // half-period length minus one, software set
   reg [2:0]       bit_r;       // bit index within byte
   reg [7:0]       sh_r;        // shift register
   reg [7:0]       tx_r;        // next byte to send
   reg [7:0]       rx_r;        // last byte received
   reg             rxv_r;       // received byte valid, sticky
   reg             rd_r;        // current frame is a read
   reg             in_start_r;  // shifting the start byte
   reg [1:0]       op_r;        // op of this frame
   reg             id_r;        // id bit used in start byte
   reg             addr_ph_r;   // pending ahb data phase
   reg             wr_ph_r;     // pending phase is a write
   reg [7:0]       adr_r;       // latched ahb address low byte
   wire            irq_s;       // synchronised interrupt level
   wire            sda_s;       // synchronised serial data in
   wire            last_div;    // half period elapsed

   // pins from the device cross into clk through three flops
   spkh_sync u_irq (.clk(clk), .reset(reset), .d_in(irq_n), .q_out(irq_s));
   spkh_sync u_sda (.clk(clk), .reset(reset), .d_in(sda_i), .q_out(sda_s));

   assign last_div = (div_r == clkdiv_r);

   // ahb-lite slave, zero wait states; order regs written in the data phase
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         addr_ph_r   <= 1'b0;
         wr_ph_r     <= 1'b0;
         adr_r       <= 8'h00;
         hrdata      <= 32'h00000000;
         hreadyout   <= 1'b1;
         hresp       <= 1'b0;
      end
      else
      begin
         addr_ph_r <= hsel & hready & htrans[1];
         wr_ph_r   <= hwrite;
         adr_r     <= haddr[7:0];
         hrdata    <= 32'h00000000;
         // read data prepared during the address phase
         if (hsel & hready & htrans[1] & ~hwrite)
         begin
            case (haddr[7:0])
               `SPKH_OFF_CTRL:   hrdata <= {26'h0, id_r, op_r[0], op_r[1], 3'h0}; // same layout as the write
               `SPKH_OFF_TXDATA: hrdata <= {24'h0, tx_r};
               `SPKH_OFF_STATUS: hrdata <= {28'h0, (state_r != ST_IDLE), ~irq_s,
                                            rxv_r, (state_r != ST_IDLE && state_r != ST_WAIT)};
               `SPKH_OFF_RXDATA: hrdata <= {24'h0, rx_r}; // raw key bytes, ghost keys left to software
               `SPKH_OFF_PINS:   hrdata <= {28'h0, register_select, mode_or_address_low_pin,
                                            iface_sel_c, iface_sel_b};
               `SPKH_OFF_CLKDIV: hrdata <= {{(32-DIV_W){1'b0}}, clkdiv_r};
               default:          hrdata <= 32'h00000000; // unmapped reads zero
            endcase
         end
      end
   end

   // serial sequencer and software-visible order state
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         state_r     <= ST_IDLE;
         div_r       <= {DIV_W{1'b0}};
         clkdiv_r    <= `SPKH_CLKDIV_RST;
         bit_r       <= 3'h0;
         sh_r        <= 8'h00;
         tx_r        <= 8'h00;
         rx_r        <= 8'h00;
         rxv_r       <= 1'b0;
         rd_r        <= 1'b0;
         in_start_r  <= 1'b0;
         op_r        <= `SPKH_OP_WR_INSTR;
         id_r        <= 1'b0;
         cs_n        <= 1'b1;
         sclk        <= 1'b1;
         sda_o       <= 1'b0;
         sda_oe      <= 1'b0;
         iface_sel_b <= 1'b0; // serial mode from reset
         iface_sel_c <= 1'b0;
         mode_or_address_low_pin <= 1'b0;
         register_select         <= 1'b0;
      end
      else
      begin
         // the divider restarts on every entry out of idle or wait, so the chip select setup,
         // each half period and the end hold all last CLKDIV+1 cycles; a free count would cut them
         div_r <= (last_div || state_r == ST_IDLE || state_r == ST_WAIT) ? {DIV_W{1'b0}} : div_r + 1'b1;
         // reading rx data clears the valid flag; a new byte wins
         if (addr_ph_r && !wr_ph_r && adr_r == `SPKH_OFF_RXDATA)
            rxv_r <= 1'b0;
         if (addr_ph_r && wr_ph_r)
         begin
            case (adr_r)
               `SPKH_OFF_TXDATA: tx_r <= hwdata[7:0];
               `SPKH_OFF_CLKDIV: clkdiv_r <= hwdata[DIV_W-1:0]; // slow rate after clear display
               `SPKH_OFF_PINS:
               begin
                  // pins frozen while a frame is open, so the mode never leaves serial mid-frame
                  if (state_r == ST_IDLE)
                  begin
                     iface_sel_b <= hwdata[`SPKH_PIN_ISB];
                     iface_sel_c <= hwdata[`SPKH_PIN_ISC];
                     mode_or_address_low_pin <= hwdata[`SPKH_PIN_MID]; // id bit of address
                     register_select <= hwdata[`SPKH_PIN_RSP]; // standby strobe choice
                  end
               end
               `SPKH_OFF_CTRL:
               begin
                  // a frame opens only in serial mode, both select pins low
                  if (hwdata[`SPKH_CTRL_START] && state_r == ST_IDLE && !iface_sel_b && !iface_sel_c)
                  begin
                     // start byte: fixed address bits, id, rs, rw
                     op_r       <= {hwdata[`SPKH_CTRL_RS], hwdata[`SPKH_CTRL_RW]};
                     id_r       <= hwdata[`SPKH_CTRL_ID];
                     rd_r       <= hwdata[`SPKH_CTRL_RW];
                     sh_r       <= {`SPKH_ADDR_HI, hwdata[`SPKH_CTRL_ID],
                                    hwdata[`SPKH_CTRL_RS], hwdata[`SPKH_CTRL_RW]};
                     in_start_r <= 1'b1;
                     cs_n       <= 1'b0; // falling edge opens the frame
                     state_r    <= ST_SETUP;
                  end
                  else if (hwdata[`SPKH_CTRL_BYTE] && state_r == ST_WAIT)
                  begin
                     // each further byte is one software order
                     sh_r    <= rd_r ? 8'h00 : tx_r;
                     state_r <= ST_SETUP;
                  end
                  else if (hwdata[`SPKH_CTRL_END] && state_r == ST_WAIT)
                     state_r <= ST_END;
               end
               default: ;
            endcase
         end
         case (state_r)
            ST_IDLE:
            begin
               // chip select is left to the start order above; assigning it here would undo the fall
               sda_oe <= 1'b0;
            end
            ST_SETUP:
            begin
               // host drives data except in read data bytes
               sda_oe  <= in_start_r | ~rd_r;
               sda_o   <= sh_r[7];
               sclk    <= 1'b1;
               bit_r   <= 3'h0;
               if (last_div)
               begin
                  sclk    <= 1'b0;
                  state_r <= ST_LOW;
               end
            end
            ST_LOW:
            begin
               if (last_div)
               begin
                  sclk    <= 1'b1; // device samples on rising edge, msb first
                  state_r <= ST_HIGH;
               end
            end
            ST_HIGH:
            begin
               if (last_div)
               begin
                  // sample incoming data at end of high half
                  sh_r <= {sh_r[6:0], sda_s};
                  if (bit_r == 3'h7)
                  begin
                     if (rd_r && !in_start_r)
                     begin
                        rx_r  <= {sh_r[6:0], sda_s};
                        rxv_r <= 1'b1;
                     end
                     in_start_r <= 1'b0;
                     sda_oe     <= 1'b0;
                     state_r    <= ST_WAIT;
                  end
                  else
                  begin
                     bit_r   <= bit_r + 3'h1;
                     sda_o   <= sh_r[6];
                     sclk    <= 1'b0;
                     state_r <= ST_LOW;
                  end
               end
            end
            ST_WAIT:
               sclk <= 1'b1;
            ST_END:
            begin
               if (last_div)
               begin
                  cs_n    <= 1'b1; // rising edge closes the frame
                  state_r <= ST_IDLE;
               end
            end
            default:
               state_r <= ST_IDLE;
         endcase
      end
   end
endmodule // spkh_host
`default_nettype wire

// ===== spkh_chk.sv
// checker for the serial pins of the key-scan host controller
`timescale 1ns/1ns
`default_nettype none
`include "spkh_consts.vh"
module spkh_chk
(
   input wire logic clk,         // system clock
   input wire logic reset,       // async reset
   input wire logic cs_n,        // chip select
   input wire logic sclk,        // serial clock
   input wire logic sda_o,       // data out
   input wire logic sda_oe,      // data drive enable
   input wire logic iface_sel_b, // mode pin b
   input wire logic iface_sel_c  // mode pin c
);
   logic       sclk_q; // sclk one cycle back
   logic [7:0] bcnt;   // rising sclk edges in frame
   logic [7:0] sh;     // bits sent on sda_o
   logic       rd_r;   // frame is a read
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // bit count still holds on the edge where cs_n rises
   always @(posedge clk or posedge reset)
      if (reset)
         {sclk_q, rd_r, bcnt, sh} <= {2'h2, 16'h0};
      else
      begin
         sclk_q <= sclk;
         if (cs_n)
            {rd_r, bcnt} <= 9'h0;
         else if (sclk && !sclk_q)
         begin
            bcnt <= bcnt + 8'h01;
            sh <= {sh[6:0], sda_o};
            rd_r <= bcnt == 8'h07 ? sda_o : rd_r; // last start bit is read/write
         end
      end
   chk_serial_mode: assert property (!cs_n |-> !iface_sel_b && !iface_sel_c)
      else $error("mode pins high in frame");
   chk_sclk_idle: assert property (cs_n |-> sclk)
      else $error("sclk low outside frame");
   chk_cs_setup: assert property ($fell(cs_n) |-> sclk [*2])
      else $error("sclk fell with chip select");
   chk_idle_release: assert property (cs_n |-> !sda_oe)
      else $error("sda driven while idle");
   chk_data_stable: assert property (sclk && sclk_q && sda_oe && $past(sda_oe) |-> $stable(sda_o))
      else $error("sda changed while sclk high");
   chk_start_addr: assert property ($rose(bcnt == 8'h08) |-> sh[7:3] == `SPKH_ADDR_HI)
      else $error("wrong chip address");
   chk_read_release: assert property (rd_r && !sclk |-> !sda_oe)
      else $error("sda driven in read byte");
   chk_whole_bytes: assert property ($rose(cs_n) |-> bcnt[2:0] == 3'h0 && bcnt != 8'h00)
      else $error("frame ended mid byte");
   cover property ($fell(cs_n));
   cover property (rd_r && !sclk);
   cover property ($rose(bcnt == 8'h28));
endmodule // spkh_chk
bind spkh_host spkh_chk spkh_chk_inst (.clk(clk), .reset(reset), .cs_n(cs_n), .sclk(sclk), .sda_o(sda_o),
   .sda_oe(sda_oe), .iface_sel_b(iface_sel_b), .iface_sel_c(iface_sel_c));
`default_nettype wire

// ===== spkh_dev_model.sv
// behavioural key-scan device behind the serial port
`timescale 1ns/1ns
`default_nettype none
`include "spkh_consts.vh"
module spkh_dev_model
(
   input  wire logic        cs_n,   // chip select, low active
   input  wire logic        sclk,   // serial clock
   input  wire logic        sda,    // resolved data line
   input  wire logic        id_pin, // address low bit
   input  wire logic        rs_pin, // register select pin, standby strobe choice
   input  wire logic [31:0] keys,   // pressed keys as the strobe scan latches them, latch n is byte n
   output logic             dev_o,  // data out
   output logic             dev_oe, // high while driving
   output logic             irq_n   // interrupt, low active
);
   logic [7:0] sh_r = 8'h00;  // received bits
   logic [7:0] tx_r = 8'h00;  // byte going out
   logic [2:0] bit_r = 3'h0;  // bit in byte
   logic [3:0] nb_r = 4'h0;   // bytes done
   logic [1:0] op_r = 2'h0;   // select, read/write
   logic       sel_r = 1'b0;  // address matched
   logic       ire_r = 1'b0;  // interrupt off after reset
   logic       stb_r = 1'b0;  // standby, scan stopped
   logic [1:0] lat_r = 2'h0;  // next latch out
   logic [7:0] ram_r = 8'h00; // last ram byte
   // standby parks strobe 0 low, or all four with the select pin high
   // sleep keeps scanning, so it leaves the interrupt as it is
   assign irq_n = !(ire_r && (stb_r && !rs_pin ? |keys[7:0] : |keys));
   // frame ends on cs_n high; bits taken on rising sclk
   always @(posedge sclk or posedge cs_n)
      if (cs_n)
         {sel_r, dev_oe, bit_r, nb_r, lat_r} = 11'h0;
      else
      begin
         sh_r = {sh_r[6:0], sda};
         bit_r = bit_r + 3'h1;
         if (bit_r == 3'h0 && nb_r == 4'h0)
            {sel_r, op_r} = {sh_r[7:2] == {`SPKH_ADDR_HI, id_pin}, sh_r[1:0]};
         else if (bit_r == 3'h0 && sel_r && op_r == `SPKH_OP_WR_RAM)
            ram_r = sh_r;
         else if (bit_r == 3'h0 && sel_r && op_r == `SPKH_OP_WR_INSTR && sh_r[7:3] == 5'h0D)
            ire_r = sh_r[2]; // key scan control word
         else if (bit_r == 3'h0 && sel_r && op_r == `SPKH_OP_WR_INSTR && sh_r[7:3] == 5'h01)
            stb_r = sh_r[0]; // power control word, standby bit
         nb_r = nb_r + {3'h0, bit_r == 3'h0};
      end
   // read data goes out on falling sclk, only in data bytes
   always @(negedge sclk)
      if (!cs_n && sel_r && op_r[0] && nb_r != 4'h0)
      begin
         if (bit_r == 3'h0)
         begin
            tx_r = !op_r[1] ? keys[lat_r*8 +: 8] : nb_r < 4'h3 ? 8'hA5 : ram_r;
            lat_r = lat_r + {1'b0, !op_r[1]}; // wraps after latch 3
         end
         dev_o = tx_r[3'h7 - bit_r];
         dev_oe = 1'b1;
      end
endmodule // spkh_dev_model
`default_nettype wire

// ===== spkh_tb.sv
// self-checking bench for the key-scan host controller
`timescale 1ns/1ns
`default_nettype none
`include "spkh_consts.vh"
module testbench;
   logic        clk = 1'b0;      // 100 MHz
   logic        reset = 1'b1;    // async reset
   logic [31:0] haddr = 32'h0;   // bus address
   logic [1:0]  htrans = 2'h0;   // transfer type
   logic        hwrite = 1'b0;   // write flag
   logic [31:0] hwdata = 32'h0;  // write data
   logic        hsel = 1'b0;     // slave select
   wire  [31:0] hrdata;          // read data
   wire         hreadyout, cs_n, sclk, sda_o, sda_oe, irq_n, dev_o, dev_oe, isb, isc, idp, rsp, hresp;
   logic        sda_last = 1'b0; // last driven level
   wire         sda = sda_oe ? sda_o : dev_oe ? dev_o : !sda_last; // released line drifts
   logic [31:0] keys = 32'h8142_2418; // pressed keys
   logic [7:0]  rxq [8];         // bytes read in a frame
   logic [31:0] v;               // last bus read
   int          miscompares = 0;
   int          checked = 0;
   // op, tx byte, byte count, expected last read byte, expected irq
   localparam logic [20:0] rows [4] = '{{`SPKH_OP_WR_RAM, 8'h5A, 2'h1, 8'h00, 1'b0},
      {`SPKH_OP_RD_RAM, 8'h00, 2'h3, 8'h5A, 1'b0}, {`SPKH_OP_WR_INSTR, 8'h6C, 2'h1, 8'h00, 1'b1},
      {`SPKH_OP_WR_INSTR, 8'h68, 2'h1, 8'h00, 1'b0}};
   always #5 clk = !clk;
   always @(posedge clk) if (sda_oe || dev_oe) sda_last <= sda;
   spkh_host spkh_host_inst (.clk(clk), .reset(reset), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hsel(hsel), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .cs_n(cs_n), .sclk(sclk), .sda_o(sda_o), .sda_oe(sda_oe), .sda_i(sda), .irq_n(irq_n),
      .iface_sel_b(isb), .iface_sel_c(isc), .mode_or_address_low_pin(idp), .register_select(rsp));
   spkh_dev_model spkh_dev_model_inst (.cs_n(cs_n), .sclk(sclk), .sda(sda), .id_pin(idp), .keys(keys),
      .rs_pin(rsp), .dev_o(dev_o), .dev_oe(dev_oe), .irq_n(irq_n));
   task check(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // one single transfer; read data taken at the data phase edge
   task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      {haddr, htrans, hwrite, hsel} <= {24'h0, a, 2'h2, wr, 1'b1};
      do @(posedge clk); while (hreadyout !== 1'b1);
      {htrans, hsel, hwdata} <= {3'h0, d};
      do @(posedge clk); while (hreadyout !== 1'b1);
      v = hrdata;
   endtask
   task poll(input logic [31:0] m, input logic [31:0] e);
      do ahb(1'b0, `SPKH_OFF_STATUS, 32'h0); while ((v & m) !== e);
   endtask
   // whole frame: start byte, nb data bytes, end
   task frame(input logic [1:0] op, input logic [7:0] tx, input int nb, input logic idb);
      ahb(1'b1, `SPKH_OFF_CTRL, {26'h0, idb, op[0], op[1], 3'h1});
      poll(32'h9, 32'h8);
      for (int i = 0; i < nb; i++)
      begin
         if (!op[0]) ahb(1'b1, `SPKH_OFF_TXDATA, {24'h0, tx});
         ahb(1'b1, `SPKH_OFF_CTRL, 32'h2);
         poll(32'h9, 32'h8);
         ahb(1'b0, `SPKH_OFF_RXDATA, 32'h0);
         rxq[i] = v[7:0];
      end
      ahb(1'b1, `SPKH_OFF_CTRL, 32'h4);
      poll(32'h8, 32'h0);
      repeat (8) @(posedge clk);
   endtask
   task end_sim;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial
   begin
      #500000;
      miscompares++;
      end_sim;
   end
   initial
   begin
      repeat (3) @(posedge clk);
      check("pins in reset", 32'h60, {25'h0, cs_n, sclk, sda_oe, isb, isc, idp, rsp});
      reset <= 1'b0;
      ahb(1'b0, `SPKH_OFF_CLKDIV, 32'h0);
      check("clkdiv reset", 32'h8, v);
      check("hresp okay", 32'h0, {31'h0, hresp});
      ahb(1'b1, 8'h1C, 32'hFF);
      ahb(1'b0, 8'h1C, 32'h0);
      check("unmapped", 32'h0, v);
      ahb(1'b1, `SPKH_OFF_PINS, 32'h4); // serial mode, id pin high
      ahb(1'b1, `SPKH_OFF_CLKDIV, 32'h7);
      check("mode pins", 32'h2, {28'h0, isb, isc, idp, rsp});
      $display("test registers done");
      for (int r = 0; r < 4; r++)
      begin
         frame(rows[r][20:19], rows[r][18:11], rows[r][10:9], 1'b1);
         if (rows[r][19]) check("read byte", rows[r][8:1], rxq[rows[r][10:9] - 1]);
         ahb(1'b0, `SPKH_OFF_STATUS, 32'h0);
         check("irq status", rows[r][0], v[2]);
         $display("test row %0d done", r);
      end
      frame(`SPKH_OP_RD_KEYS, 8'h00, 5, 1'b1);
      for (int i = 0; i < 5; i++) check("key latch", keys[(i % 4)*8 +: 8], rxq[i]);
      frame(`SPKH_OP_WR_INSTR, 8'h6C, 1, 1'b0);
      ahb(1'b0, `SPKH_OFF_STATUS, 32'h0);
      check("foreign address", 32'h0, v[2]);
      $display("test keys and address done");
      keys <= 32'h0000_2400; // nothing pressed on strobe 0
      frame(`SPKH_OP_WR_INSTR, 8'h6C, 1, 1'b1); // interrupt enable on
      frame(`SPKH_OP_WR_INSTR, 8'h09, 1, 1'b1); // standby on
      ahb(1'b0, `SPKH_OFF_STATUS, 32'h0);
      check("standby strobe 0", 32'h0, v[2]);
      ahb(1'b1, `SPKH_OFF_PINS, 32'hC);
      repeat (8) @(posedge clk);
      ahb(1'b0, `SPKH_OFF_STATUS, 32'h0);
      check("standby all strobes", 32'h1, v[2]);
      ahb(1'b1, `SPKH_OFF_PINS, 32'h4); // select pin back low
      frame(`SPKH_OP_WR_INSTR, 8'h0A, 1, 1'b1); // sleep on, standby off
      ahb(1'b0, `SPKH_OFF_STATUS, 32'h0);
      check("sleep irq", 32'h1, v[2]);
      $display("test standby and sleep done");
      reset <= 1'b1;
      @(posedge clk);
      check("pins second reset", 32'h60, {25'h0, cs_n, sclk, sda_oe, isb, isc, idp, rsp});
      reset <= 1'b0;
      ahb(1'b0, `SPKH_OFF_CLKDIV, 32'h0);
      check("clkdiv second reset", 32'h8, v);
      $display("test second reset done");
      end_sim;
   end
endmodule // testbench
`default_nettype wire
